//--- include/diff_div_cfg.svh
// Register indices, field positions and reset values of the channel dividers
`ifndef DIFF_DIV_CFG_SVH
`define DIFF_DIV_CFG_SVH

// Register indices; byte address is four times the index
`define DD_IDX_P1_ROUTE 9'h195
`define DD_IDX_P2_COUNTS 9'h196
`define DD_IDX_P2_CTRL 9'h197
`define DD_IDX_P2_ROUTE 9'h198
`define DD_IDX_INPUT_SEL 9'h1e1
`define DD_IDX_STATUS 9'h1f0
`define DD_ADDR_LSB_PAD 2'h0
`define DD_ADDR_W 12

// Route register fields
`define DD_ROUTE_DIRECT 1
`define DD_ROUTE_DCC_OFF 0
// Phase count fields
`define DD_LOW_MSB 7
`define DD_LOW_LSB 4
`define DD_HIGH_MSB 3
`define DD_HIGH_LSB 0
// Control fields
`define DD_CTRL_BYPASS 7
`define DD_CTRL_NOSYNC 6
`define DD_CTRL_FORCE 5
`define DD_CTRL_START 4
`define DD_PHASE_MSB 3
`define DD_PHASE_LSB 0

// Input select codes
`define DD_SEL_OSC 2'h2
`define DD_SEL_CLK 2'h0

// Reset values
`define DD_RST_COUNTS 8'h00
`define DD_RST_CTRL 8'h00
`define DD_RST_ROUTE 2'h0
`define DD_RST_SEL 2'h0
// Fixed settings of the first pair divider
`define DD_P1_COUNTS 8'h00
`define DD_P1_CTRL 8'h00

// Counter constants
`define DD_CNT_ZERO 5'h00
`define DD_CNT_ONE 5'h01
`define DD_PHASE_EXTRA 6'h02
`define DD_PHASE_NONE 4'h0

`endif

//--- include/diff_div_pkg.sv
// Types shared by the channel divider design
package diff_div_pkg;
   typedef enum logic [1:0] {div_hold, div_delay, div_run} div_state_t;
endpackage

//--- verilog/channel_divider.sv
// One channel divider counting rising edges of its input clock
`timescale 1ns/10ps
`include "diff_div_cfg.svh"
module channel_divider (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic src_level,
   input wire logic src_rise,
   input wire logic [3:0] low_count,
   input wire logic [3:0] high_count,
   input wire logic bypass,
   input wire logic nosync,
   input wire logic force_level,
   input wire logic start_high,
   input wire logic [3:0] phase_offset,
   input wire logic dcc_disable,
   input wire logic sync_active,
   output logic div_out
);
   diff_div_pkg::div_state_t state_q;
   diff_div_pkg::div_state_t state_d;
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic out_q;
   logic out_d;
   wire logic [5:0] total_w;
   wire logic [4:0] half_w;
   wire logic [4:0] hi_lim_w;
   wire logic [4:0] lo_lim_w;
   wire logic [4:0] limit_w;
   wire logic [4:0] delay_last_w;
   wire logic at_limit_w;
   wire logic at_delay_end_w;

   // Period and duty split
   assign total_w = 6'({2'h0, low_count}) + 6'({2'h0, high_count}) + `DD_PHASE_EXTRA;
   assign half_w = total_w[5:1];
   assign hi_lim_w = dcc_disable ? {1'b0, high_count} : half_w - `DD_CNT_ONE;
   assign lo_lim_w = dcc_disable ? {1'b0, low_count} :
                     5'(total_w - {1'b0, half_w}) - `DD_CNT_ONE;
   assign limit_w = out_q ? hi_lim_w : lo_lim_w;
   assign at_limit_w = (cnt_q >= limit_w);
   assign delay_last_w = {1'b0, phase_offset} - `DD_CNT_ONE;
   assign at_delay_end_w = (cnt_q >= delay_last_w);

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      out_d = out_q;
      if (bypass) begin
         state_d = diff_div_pkg::div_hold;
         cnt_d = `DD_CNT_ZERO;
         out_d = src_level;
      end else if (sync_active && !nosync) begin
         state_d = diff_div_pkg::div_hold;
         cnt_d = `DD_CNT_ZERO;
         out_d = start_high;
      end else if (sync_active) begin
         out_d = force_level;
      end else begin
         unique case (state_q)
            diff_div_pkg::div_hold: begin
               cnt_d = `DD_CNT_ZERO;
               out_d = start_high;
               state_d = (phase_offset == `DD_PHASE_NONE) ? diff_div_pkg::div_run :
                         diff_div_pkg::div_delay;
            end
            diff_div_pkg::div_delay: begin
               if (src_rise && at_delay_end_w) begin
                  state_d = diff_div_pkg::div_run;
                  cnt_d = `DD_CNT_ZERO;
               end else if (src_rise) begin
                  cnt_d = cnt_q + `DD_CNT_ONE;
               end
            end
            diff_div_pkg::div_run: begin
               if (src_rise && at_limit_w) begin
                  out_d = ~out_q;
                  cnt_d = `DD_CNT_ZERO;
               end else if (src_rise) begin
                  cnt_d = cnt_q + `DD_CNT_ONE;
               end
            end
            default: begin
               state_d = diff_div_pkg::div_hold;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= diff_div_pkg::div_hold;
         cnt_q <= `DD_CNT_ZERO;
         out_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end

   assign div_out = out_q;
endmodule // channel_divider

//--- verilog/differential_channel_divider.sv
// Two differential output pairs with routing, dividers and APB registers
//
// Functional notes
// - Route bit clear drives pair from divider
// - Route set, select 10b routes oscillator
// - Second pair, select 00b routes clock input
// - First pair, select 00b routes oscillator
// - Correction-disable clear evens the duty cycle
// - Low field sets low-phase input cycles
// - High field sets high-phase input cycles
// - Bypass passes input clock to output
// - Sync-ignore clear makes divider obey sync
// - Force bit sets level; needs sync-ignore
// - Start bit picks initial output level
// - Four-bit phase offset delays divider start
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`include "diff_div_cfg.svh"
module differential_channel_divider (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_in,
   input wire logic clk_in,
   input wire logic sync_n,
   output logic pair_one_output_a,
   output logic pair_one_output_b,
   output logic pair_two_output_a,
   output logic pair_two_output_b
);
   // APB state
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic pslverr_d;
   logic [31:0] prdata_d;

   // Software registers
   logic [1:0] p1_route_q;
   logic [7:0] p2_counts_q;
   logic [7:0] p2_ctrl_q;
   logic [1:0] p2_route_q;
   logic [1:0] input_sel_q;

   // Pin synchronisers: osc_in, clk_in, sync_n
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic [2:0] pin_s3_q;
   logic [2:0] pin_lvl_q;
   logic [2:0] pin_prev_q;
   wire logic [2:0] pin_raw_w;
   wire logic [2:0] pin_rise_w;

   // Divider and output state
   wire logic [1:0] div_level_w;
   logic [1:0] out_a_q;
   logic [1:0] out_b_q;
   wire logic [1:0] route_mux_w;
   wire logic [7:0] counts_w [2];
   wire logic [7:0] ctrl_w [2];
   wire logic [1:0] route_w [2];

   // Bus decode
   wire logic [8:0] idx_w;
   wire logic word_ok_w;
   wire logic setup_w;
   wire logic wr_en_w;
   wire logic hit_p1_route_w;
   wire logic hit_p2_counts_w;
   wire logic hit_p2_ctrl_w;
   wire logic hit_p2_route_w;
   wire logic hit_input_sel_w;
   wire logic hit_status_w;
   wire logic hit_any_w;
   wire logic [31:0] rd_p1_route_w;
   wire logic [31:0] rd_p2_counts_w;
   wire logic [31:0] rd_p2_ctrl_w;
   wire logic [31:0] rd_p2_route_w;
   wire logic [31:0] rd_input_sel_w;
   wire logic [31:0] rd_status_w;

   // Source selection
   wire logic osc_lvl_w;
   wire logic clk_lvl_w;
   wire logic sync_active_w;
   wire logic use_osc_w;
   wire logic src_lvl_w;
   wire logic src_rise_w;
   wire logic sel_is_osc_w;
   wire logic sel_is_clk_w;

   // Pin inputs: three flops, level moves when second and third agree
   assign pin_raw_w = {sync_n, clk_in, osc_in};

   generate
      for (genvar i = 0; i < 3; i++) begin : g_pin
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_s1_q[i] <= 1'b0;
               pin_s2_q[i] <= 1'b0;
               pin_s3_q[i] <= 1'b0;
            end else begin
               pin_s1_q[i] <= pin_raw_w[i];
               pin_s2_q[i] <= pin_s1_q[i];
               pin_s3_q[i] <= pin_s2_q[i];
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_lvl_q[i] <= 1'b0;
               pin_prev_q[i] <= 1'b0;
            end else begin
               pin_lvl_q[i] <= (pin_s2_q[i] == pin_s3_q[i]) ? pin_s3_q[i] : pin_lvl_q[i];
               pin_prev_q[i] <= pin_lvl_q[i];
            end
         end

         assign pin_rise_w[i] = pin_lvl_q[i] & ~pin_prev_q[i];
      end
   endgenerate

   assign osc_lvl_w = pin_lvl_q[0];
   assign clk_lvl_w = pin_lvl_q[1];
   // Sync pin is active low; reset value zero means sync held until pin settles
   assign sync_active_w = ~pin_lvl_q[2];

   // Divider input: oscillator when select is 10b, else the clock input
   assign sel_is_osc_w = (input_sel_q == `DD_SEL_OSC);
   assign sel_is_clk_w = (input_sel_q == `DD_SEL_CLK);
   assign use_osc_w = sel_is_osc_w;
   assign src_lvl_w = use_osc_w ? osc_lvl_w : clk_lvl_w;
   assign src_rise_w = use_osc_w ? pin_rise_w[0] : pin_rise_w[1];

   // Per-pair settings; the first pair divider runs with fixed settings
   assign counts_w[0] = `DD_P1_COUNTS;
   assign ctrl_w[0] = `DD_P1_CTRL;
   assign route_w[0] = p1_route_q;
   assign counts_w[1] = p2_counts_q;
   assign ctrl_w[1] = p2_ctrl_q;
   assign route_w[1] = p2_route_q;

   generate
      for (genvar p = 0; p < 2; p++) begin : g_pair
         channel_divider u_div (
            .pclk(pclk),
            .presetn(presetn),
            .src_level(src_lvl_w),
            .src_rise(src_rise_w),
            .low_count(counts_w[p][`DD_LOW_MSB:`DD_LOW_LSB]),
            .high_count(counts_w[p][`DD_HIGH_MSB:`DD_HIGH_LSB]),
            .bypass(ctrl_w[p][`DD_CTRL_BYPASS]),
            .nosync(ctrl_w[p][`DD_CTRL_NOSYNC]),
            .force_level(ctrl_w[p][`DD_CTRL_FORCE]),
            .start_high(ctrl_w[p][`DD_CTRL_START]),
            .phase_offset(ctrl_w[p][`DD_PHASE_MSB:`DD_PHASE_LSB]),
            .dcc_disable(route_w[p][`DD_ROUTE_DCC_OFF]),
            .sync_active(sync_active_w),
            .div_out(div_level_w[p])
         );

         // Output routing
         if (p == 0) begin : g_first
            assign route_mux_w[p] =
               !route_w[p][`DD_ROUTE_DIRECT] ? div_level_w[p] :
               sel_is_osc_w ? osc_lvl_w :
               sel_is_clk_w ? osc_lvl_w :
               div_level_w[p];
         end else begin : g_second
            assign route_mux_w[p] =
               !route_w[p][`DD_ROUTE_DIRECT] ? div_level_w[p] :
               sel_is_osc_w ? osc_lvl_w :
               sel_is_clk_w ? clk_lvl_w :
               div_level_w[p];
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               out_a_q[p] <= 1'b0;
               out_b_q[p] <= 1'b1;
            end else begin
               out_a_q[p] <= route_mux_w[p];
               out_b_q[p] <= ~route_mux_w[p];
            end
         end
      end
   endgenerate

   assign pair_one_output_a = out_a_q[0];
   assign pair_one_output_b = out_b_q[0];
   assign pair_two_output_a = out_a_q[1];
   assign pair_two_output_b = out_b_q[1];

   // APB decode: word index in paddr[10:2]
   assign idx_w = paddr[10:2];
   assign word_ok_w = (paddr[1:0] == `DD_ADDR_LSB_PAD) && !paddr[11];
   assign setup_w = psel & ~penable;
   assign wr_en_w = psel & penable & pready_q & pwrite & ~pslverr_q;

   assign hit_p1_route_w = word_ok_w && (idx_w == `DD_IDX_P1_ROUTE);
   assign hit_p2_counts_w = word_ok_w && (idx_w == `DD_IDX_P2_COUNTS);
   assign hit_p2_ctrl_w = word_ok_w && (idx_w == `DD_IDX_P2_CTRL);
   assign hit_p2_route_w = word_ok_w && (idx_w == `DD_IDX_P2_ROUTE);
   assign hit_input_sel_w = word_ok_w && (idx_w == `DD_IDX_INPUT_SEL);
   assign hit_status_w = word_ok_w && (idx_w == `DD_IDX_STATUS);
   assign hit_any_w = hit_p1_route_w | hit_p2_counts_w | hit_p2_ctrl_w |
                      hit_p2_route_w | hit_input_sel_w | hit_status_w;

   // Read values, upper bits zero
   assign rd_p1_route_w = {30'h0, p1_route_q};
   assign rd_p2_counts_w = {24'h0, p2_counts_q};
   assign rd_p2_ctrl_w = {24'h0, p2_ctrl_q};
   assign rd_p2_route_w = {30'h0, p2_route_q};
   assign rd_input_sel_w = {30'h0, input_sel_q};
   assign rd_status_w = {25'h0, sync_active_w, div_level_w, out_a_q, out_a_q ^ out_b_q};

   // Read data captured in setup; status is read-only
   always_comb begin
      prdata_d = 32'h0;
      if (hit_p1_route_w) begin
         prdata_d = rd_p1_route_w;
      end else if (hit_p2_counts_w) begin
         prdata_d = rd_p2_counts_w;
      end else if (hit_p2_ctrl_w) begin
         prdata_d = rd_p2_ctrl_w;
      end else if (hit_p2_route_w) begin
         prdata_d = rd_p2_route_w;
      end else if (hit_input_sel_w) begin
         prdata_d = rd_input_sel_w;
      end else if (hit_status_w) begin
         prdata_d = rd_status_w;
      end
   end

   assign pslverr_d = !hit_any_w || (hit_status_w && pwrite);

   // No wait state: pready rises in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else if (setup_w) begin
         pready_q <= 1'b1;
         pslverr_q <= pslverr_d;
         prdata_q <= pwrite ? 32'h0 : prdata_d;
      end else begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;

   // Register writes at the completing access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p1_route_q <= `DD_RST_ROUTE;
         p2_route_q <= `DD_RST_ROUTE;
         input_sel_q <= `DD_RST_SEL;
      end else if (wr_en_w) begin
         if (hit_p1_route_w) begin
            p1_route_q <= pwdata[1:0];
         end
         if (hit_p2_route_w) begin
            p2_route_q <= pwdata[1:0];
         end
         if (hit_input_sel_w) begin
            input_sel_q <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p2_counts_q <= `DD_RST_COUNTS;
         p2_ctrl_q <= `DD_RST_CTRL;
      end else if (wr_en_w) begin
         if (hit_p2_counts_w) begin
            p2_counts_q <= pwdata[7:0];
         end
         if (hit_p2_ctrl_w) begin
            p2_ctrl_q <= pwdata[7:0];
         end
      end
   end
endmodule // differential_channel_divider

//--- tb/dcd_asserts.sv
// Checker of bus timing, routing and held levels at the top ports
`timescale 1ns/10ps
module dcd_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic osc_in,
   input wire logic clk_in,
   input wire logic sync_n,
   input wire logic pair_one_output_a,
   input wire logic pair_one_output_b,
   input wire logic pair_two_output_a,
   input wire logic pair_two_output_b
);
   logic [1:0] r1_q, r2_q, sel_q;
   logic [7:0] ctl_q;
   logic wr;
   logic [13:0] cfg;
   assign wr = psel && penable && pready && pwrite && !pslverr;
   assign cfg = {r1_q, r2_q, sel_q, ctl_q};
   // Shadow of routing and control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r1_q <= 2'h0;
         r2_q <= 2'h0;
         sel_q <= 2'h0;
         ctl_q <= 8'h00;
      end else if (wr) begin
         case (paddr)
            12'h654: r1_q <= pwdata[1:0];
            12'h660: r2_q <= pwdata[1:0];
            12'h784: sel_q <= pwdata[1:0];
            12'h65c: ctl_q <= pwdata[7:0];
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   misaligned_refused_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
      else $error("misaligned access accepted");
   pair_complement_a: assert property (
      pair_one_output_b == !pair_one_output_a && pair_two_output_b == !pair_two_output_a)
      else $error("pair outputs not complementary");
   force_level_a: assert property (
      (!sync_n && ctl_q[7:6] == 2'h1 && r2_q == 2'h1 && $stable(cfg))[*8]
      |-> pair_two_output_a == ctl_q[5]) else $error("forced level wrong");
   start_level_a: assert property (
      (!sync_n && ctl_q[7:6] == 2'h0 && r2_q == 2'h1 && $stable(cfg))[*8]
      |-> pair_two_output_a == ctl_q[4]) else $error("held start level wrong");
   bypass_follow_a: assert property (
      (sync_n && ctl_q[7] && !r2_q[1] && sel_q == 2'h2 && osc_in && $stable(cfg))[*8]
      |-> pair_two_output_a) else $error("bypass does not follow source");
   osc_direct_a: assert property (
      (r2_q[1] && sel_q == 2'h2 && osc_in && $stable(cfg))[*8]
      |-> pair_two_output_a) else $error("oscillator not routed");
   clk_direct_a: assert property (
      (r2_q[1] && sel_q == 2'h0 && clk_in && $stable(cfg))[*8]
      |-> pair_two_output_a) else $error("clock input not routed");
   pair_one_direct_a: assert property (
      (r1_q[1] && sel_q == 2'h0 && osc_in && $stable(cfg))[*8]
      |-> pair_one_output_a) else $error("first pair not routed");
   cover property (pready && pslverr);
   cover property (pready && pwrite && !pslverr);
   cover property (sync_n && $rose(pair_two_output_a));
endmodule // dcd_asserts

bind differential_channel_divider dcd_asserts i_dcd_asserts (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_in(osc_in), .clk_in(clk_in),
   .sync_n(sync_n), .pair_one_output_a(pair_one_output_a),
   .pair_one_output_b(pair_one_output_b), .pair_two_output_a(pair_two_output_a),
   .pair_two_output_b(pair_two_output_b));

//--- tb/clock_source_model.sv
// Far side: oscillator and clock sources, and a meter on the second pair
`timescale 1ns/10ps
module clock_source_model #(
   parameter int OSC_HALF = 10,
   parameter int CLK_HALF = 12
) (
   input wire logic pclk,
   input wire logic osc_run,
   input wire logic out_level,
   output logic osc_in,
   output logic clk_in,
   output logic [7:0] high_len,
   output logic [7:0] low_len
);
   int osc_cnt = 0;
   int clk_cnt = 0;
   logic [7:0] run_len = 8'h01;
   logic last_level = 1'b0;
   logic chg;
   assign chg = out_level !== last_level;
   initial begin
      osc_in = 1'b0;
      clk_in = 1'b0;
      high_len = 8'h00;
      low_len = 8'h00;
   end
   // Sources toggle each half period; the oscillator may be stopped
   always @(posedge pclk) begin
      osc_cnt <= (!osc_run || osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
      osc_in <= (osc_run && osc_cnt == OSC_HALF - 1) ? !osc_in : osc_in;
      clk_cnt <= (clk_cnt == CLK_HALF - 1) ? 0 : clk_cnt + 1;
      clk_in <= (clk_cnt == CLK_HALF - 1) ? !clk_in : clk_in;
      // Length of each settled output level in pclk cycles
      last_level <= out_level;
      run_len <= chg ? 8'h01 : run_len + 8'h01;
      high_len <= (chg && last_level) ? run_len : high_len;
      low_len <= (chg && !last_level) ? run_len : low_len;
   end
endmodule // clock_source_model

//--- tb/testbench.sv
// Self-checking bench for the differential channel divider
`timescale 1ns/10ps
module testbench;
   typedef struct {logic [1:0] sel; logic [7:0] rt, cnt, ctl, hi, lo;} row_t;
   logic pclk, presetn, psel, penable, pwrite, sync_n, osc_run, pready, pslverr, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic osc_in, clk_in, o1a, o1b, o2a, o2b;
   logic [7:0] high_len, low_len;
   int mismatches = 0;
   int total_checks = 0;
   int dly[2];
   logic [11:0] raddr[5] = '{12'h654, 12'h658, 12'h65c, 12'h660, 12'h784};
   logic [7:0] fctl[4] = '{8'h60, 8'h40, 8'h30, 8'h20};
   row_t rows[9] = '{'{2'h2, 8'h01, 8'h00, 8'h00, 8'h14, 8'h14},
      '{2'h2, 8'h01, 8'h30, 8'h00, 8'h14, 8'h50}, '{2'h2, 8'h00, 8'h30, 8'h00, 8'h28, 8'h3c},
      '{2'h0, 8'h01, 8'h10, 8'h00, 8'h18, 8'h30}, '{2'h2, 8'h01, 8'h30, 8'h80, 8'h0a, 8'h0a},
      '{2'h1, 8'h03, 8'h00, 8'h00, 8'h18, 8'h18}, '{2'h2, 8'h03, 8'h00, 8'h00, 8'h0a, 8'h0a},
      '{2'h3, 8'h03, 8'h00, 8'h00, 8'h18, 8'h18}, '{2'h0, 8'h03, 8'h00, 8'h00, 8'h0c, 8'h0c}};
   differential_channel_divider i_differential_channel_divider (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
      .clk_in(clk_in), .sync_n(sync_n), .pair_one_output_a(o1a), .pair_one_output_b(o1b),
      .pair_two_output_a(o2a), .pair_two_output_b(o2b));
   clock_source_model i_clock_source_model (.pclk(pclk), .osc_run(osc_run), .out_level(o2a),
      .osc_in(osc_in), .clk_in(clk_in), .high_len(high_len), .low_len(low_len));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         mismatches++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One transfer, then one idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         mismatches++;
         close_out();
      end
      @(posedge pclk);
   endtask
   task automatic wait_osc(input logic v);
      int n;
      n = 0;
      while (osc_in !== v && n < 100) begin
         @(posedge pclk);
         n++;
      end
      chk("oscillator wait", {31'h0, v}, {31'h0, osc_in});
      if (osc_in !== v) begin
         close_out();
      end
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sync_n = 1'b1;
      osc_run = 1'b1;
      cyc(5);
      chk("reset out b", 32'h1, {31'h0, o2b});
      chk("reset ready", 32'h0, {31'h0, pready});
      cyc(5);
      presetn <= 1'b1;
      cyc(1);
      foreach (raddr[i]) begin
         apb(1'b0, raddr[i], 32'h0);
         chk("reset value", 32'h0, rdata);
      end
      apb(1'b0, 12'h000, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, rerr});
      chk("unmapped data", 32'h0, rdata);
      apb(1'b0, 12'h656, 32'h0);
      chk("misaligned error", 32'h1, {31'h0, rerr});
      apb(1'b0, 12'he54, 32'h0);
      chk("upper address error", 32'h1, {31'h0, rerr});
      chk("upper address data", 32'h0, rdata);
      apb(1'b0, 12'h7c0, 32'h0);
      chk("status fixed bits", 32'h0000_0003, rdata & 32'hffff_ffc3);
      apb(1'b1, 12'h7c0, 32'hff);
      chk("status write error", 32'h1, {31'h0, rerr});
      apb(1'b1, 12'h658, 32'hffff_ffff);
      apb(1'b0, 12'h658, 32'h0);
      chk("counts readback", 32'h0000_00ff, rdata);
      $display("test registers done");
      foreach (rows[i]) begin
         apb(1'b1, 12'h784, {30'h0, rows[i].sel});
         apb(1'b1, 12'h660, {24'h0, rows[i].rt});
         apb(1'b1, 12'h658, {24'h0, rows[i].cnt});
         apb(1'b1, 12'h65c, {24'h0, rows[i].ctl});
         cyc(300);
         chk("high length", {24'h0, rows[i].hi}, {24'h0, high_len});
         chk("low length", {24'h0, rows[i].lo}, {24'h0, low_len});
      end
      $display("test rows done");
      apb(1'b1, 12'h654, 32'h2);
      wait_osc(1'b1);
      osc_run <= 1'b0;
      repeat (4) begin
         cyc(12);
         chk("first pair direct", {31'h0, osc_in}, {31'h0, o1a});
      end
      $display("test first pair done");
      osc_run <= 1'b1;
      apb(1'b1, 12'h654, 32'h0);
      apb(1'b1, 12'h784, 32'h2);
      apb(1'b1, 12'h660, 32'h1);
      apb(1'b1, 12'h658, 32'h0);
      sync_n <= 1'b0;
      foreach (fctl[i]) begin
         apb(1'b1, 12'h65c, {24'h0, fctl[i]});
         cyc(20);
         chk("held level", {31'h0, fctl[i][6] ? fctl[i][5] : fctl[i][4]}, {31'h0, o2a});
      end
      $display("test held levels done");
      foreach (dly[i]) begin
         apb(1'b1, 12'h65c, (i == 0) ? 32'h0 : 32'h3);
         cyc(10);
         wait_osc(1'b0);
         wait_osc(1'b1);
         sync_n <= 1'b1;
         dly[i] = 0;
         while (o2a !== 1'b1 && dly[i] < 400) begin
            @(posedge pclk);
            dly[i]++;
         end
         if (dly[i] >= 400) begin
            mismatches++;
            close_out();
         end
         sync_n <= 1'b0;
      end
      chk("offset delay", 32'h3c, dly[1] - dly[0]);
      $display("test phase offset done");
      close_out();
   end
endmodule // testbench
